// *** sosc_defines.svh ***
// Timing, address and field constants of the supervisor output control block
`ifndef SOSC_DEFINES_SVH
`define SOSC_DEFINES_SVH

// Clock and time bases, each in nanoseconds
`define SOSC_CLK_NS 10
`define SOSC_TICK_NS 12500
`define SOSC_MR_GLITCH_NS 100
`define SOSC_SPIKE_NS 50
`define SOSC_NVW_NS 11000000
// Cycle counts derived from the times above, except the fixed general input filter count
`define SOSC_TICK_CYC (`SOSC_TICK_NS / `SOSC_CLK_NS)
`define SOSC_MR_FILT_CYC (`SOSC_MR_GLITCH_NS / `SOSC_CLK_NS + 1)
`define SOSC_SPIKE_FILT_CYC (`SOSC_SPIKE_NS / `SOSC_CLK_NS + 1)
`define SOSC_GPI_FILT_CYC 1
`define SOSC_NVW_CYC (`SOSC_NVW_NS / `SOSC_CLK_NS)

// Watchdog timeouts in 12.5 us ticks, codes 000..111
`define SOSC_WD_T0 24'h0001f4
`define SOSC_WD_T1 24'h0007d0
`define SOSC_WD_T2 24'h001f40
`define SOSC_WD_T3 24'h007d00
`define SOSC_WD_T4 24'h01f400
`define SOSC_WD_T5 24'h07d000
`define SOSC_WD_T6 24'h1f4000
`define SOSC_WD_T7 24'h7d0000

// Output deassert delays in 12.5 us ticks, 25 us .. 1600 ms
`define SOSC_DLY_T0 17'h00002
`define SOSC_DLY_T1 17'h0007d
`define SOSC_DLY_T2 17'h001f4
`define SOSC_DLY_T3 17'h007d0
`define SOSC_DLY_T4 17'h00fa0
`define SOSC_DLY_T5 17'h03e80
`define SOSC_DLY_T6 17'h07d00
`define SOSC_DLY_T7 17'h1f400

// Register byte addresses
`define SOSC_A_MODE 8'h00
`define SOSC_A_MARGIN_STATE 8'h04
`define SOSC_A_MR_STATE 8'h08
`define SOSC_A_WD0 8'h0c
`define SOSC_A_WD1 8'h10
`define SOSC_A_STATUS 8'h14
`define SOSC_A_BUSADDR 8'h18
`define SOSC_A_PO_BASE 8'h20
`define SOSC_A_PO_LAST 8'h3c

// Mode register fields
`define SOSC_MODE_FREEZE 0
`define SOSC_MODE_MR_EN 1
// Watchdog config fields
`define SOSC_WD_CODE 2:0
`define SOSC_WD_CLR 4:3
`define SOSC_WD_GPI 6:5
`define SOSC_WD_PO 9:7
`define SOSC_WD_EN 10
// Output config fields
`define SOSC_PO_GPI_MASK 3:0
`define SOSC_PO_WD_MASK 5:4
`define SOSC_PO_DLY 8:6
`define SOSC_PO_ACT_LOW 9

// Reset values and answers
`define SOSC_MODE_RST 2'h0
`define SOSC_STATE_RST 8'h00
`define SOSC_WD_RST 11'h000
`define SOSC_PO_RST 10'h000
`define SOSC_RESP_OKAY 2'h0
`define SOSC_RESP_SLVERR 2'h2

`endif

// *** sosc_pkg.sv ***
// Types shared by the supervisor output control block
package sosc_pkg;

    // Watchdog clear source, in field order
    typedef enum logic [1:0] {
        SOSC_CLR_BOTH,
        SOSC_CLR_GPI,
        SOSC_CLR_PO,
        SOSC_CLR_OFF
    } sosc_clr_type;

endpackage : sosc_pkg

// *** sosc_filter.sv ***
// Two-flop synchroniser followed by a stability filter for one pin
module sosc_filter #(
    parameter int unsigned STABLE  = 1,
    parameter logic        RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level
);

    logic       sync1;   // First stage, read only by sync2
    logic       sync2;   // Second stage, safe to use
    logic [3:0] stab;    // Cycles sync2 has differed from level

    // Synchroniser; idle level follows the pin's pull so a floating input stays inactive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= RST_VAL;
            sync2 <= RST_VAL;
        end
        else
        begin
            sync1 <= pin;
            sync2 <= sync1;
        end
    end

    // Level follows only after STABLE agreeing cycles; shorter pulses never reach it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stab  <= 4'h0;
            level <= RST_VAL;
        end
        else if (sync2 == level)
        begin
            stab <= 4'h0;
        end
        else if (stab == 4'(STABLE - 1))
        begin
            stab  <= 4'h0;
            level <= sync2;
        end
        else
        begin
            stab <= stab + 4'h1;
        end
    end

endmodule : sosc_filter

// *** sosc_wdog.sv ***
// One watchdog timer counting in base ticks
`include "sosc_defines.svh"

module sosc_wdog (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       tick,
    input  wire logic       enable,
    input  wire logic [2:0] code,
    input  wire logic       kick,
    output logic            expired
);

    logic [23:0] cnt;    // Ticks since the last kick
    logic [23:0] limit;  // Timeout in ticks for the current code
    logic [23:0] tmo_tab [8]; // Timeouts by code

    // Timeout table, 6.25 ms to 102.4 s
    assign tmo_tab = '{`SOSC_WD_T0, `SOSC_WD_T1, `SOSC_WD_T2, `SOSC_WD_T3,
                       `SOSC_WD_T4, `SOSC_WD_T5, `SOSC_WD_T6, `SOSC_WD_T7};
    assign limit = tmo_tab[code]; // RULE1

    // Kick restarts the count; expiry holds until the next kick or until the watchdog is disabled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt     <= 24'h000000;
            expired <= 1'b0;
        end
        else if (kick || !enable)
        begin
            cnt     <= 24'h000000; // RULE17
            expired <= 1'b0;
        end
        else if (tick && !expired)
        begin
            if (cnt == limit - 24'h000001)
            begin
                expired <= 1'b1; // RULE17
            end
            cnt <= cnt + 24'h000001;
        end
    end

endmodule : sosc_wdog

// *** sosc_top.sv ***
// Supervisor output control: pin filters, watchdogs, output logic, AXI4-Lite registers
// Function
// [RULE1] Watchdog timeout chosen by 3-bit code
// [RULE2] Watchdog input pulses last at least 50 ns
// [RULE3] Manual reset: 1 us accepted, 100 ns rejected
// [RULE4] Manual reset reaches outputs within 2 us
// [RULE5] Input change reaches mapped output within 200 ns
// [RULE6] Margin low forces or freezes outputs
// [RULE7] Manual reset low forces outputs or nothing
// [RULE8] Margin wins over manual reset
// [RULE9] Outputs low until supply passes lockout
// [RULE10] Two pins select one of four addresses
// [RULE11] Serial and address pins drop 50 ns spikes
// [RULE12] Host waits 11 ms per memory write
// [RULE13] First configuration write takes an extra cycle
// [RULE14] Two independent watchdogs driving chosen outputs
// [RULE15] Watchdog cleared by input, output, or both
// [RULE16] Outputs deassert after 25 us to 1600 ms
// [RULE17] Watchdog restarts on clear, expires otherwise
// [RULE18] Floating reset and margin inputs read inactive
`include "sosc_defines.svh"

module sosc_top #(
    parameter int unsigned TICK_CYCLES = `SOSC_TICK_CYC,
    parameter int unsigned NVW_CYCLES  = `SOSC_NVW_CYC,
    parameter logic [6:0]  ADDR_BASE   = 7'h2c
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        manual_reset_n,
    input  wire logic        margin_n,
    input  wire logic [3:0]  general_logic_input,
    input  wire logic        supply_above_lockout,
    input  wire logic        bus_addr_sel0,
    input  wire logic        bus_addr_sel1,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             scl_clean,
    output logic             sda_clean,
    output logic [6:0]       bus_address,
    output logic [7:0]       programmable_output
);

    // Filtered pin levels
    logic       mr_f;          // Manual reset, low active
    logic       margin_f;      // Margin, low active
    logic [3:0] gpi_f;         // General inputs
    logic       supply_f;      // Supply above lockout
    logic       sel0_f;        // Address select 0
    logic       sel1_f;        // Address select 1
    logic       scl_f;         // Serial clock after filter
    logic       sda_f;         // Serial data after filter

    // Software-visible configuration
    logic [1:0]  mode_reg;     // Freeze and manual reset enable
    logic [7:0]  margin_state; // Output pattern under margin force
    logic [7:0]  mr_state;     // Output pattern under manual reset
    logic [10:0] wd_cfg [2];   // Watchdog configuration
    logic [9:0]  po_cfg [8];   // Per-output configuration

    // Timing and memory-write state
    logic [15:0] tick_cnt;     // Divider toward the 12.5 us tick
    logic        tick;         // One-cycle base tick
    logic [23:0] nv_cnt;       // Remaining memory-write busy cycles
    logic        first_done;   // A configuration write has completed once
    logic        nv_busy;      // A memory write is in progress
    logic [1:0]  wd_exp;       // Watchdog expiry levels
    logic [7:0]  asserted;     // Per-output assert state, held through the deassert delay
    logic [7:0]  next_po;      // Next output pattern

    // Decode of a register address to a writable slot
    function automatic logic is_rw(input logic [7:0] a);
        is_rw = (a == `SOSC_A_MODE) || (a == `SOSC_A_MARGIN_STATE) || (a == `SOSC_A_MR_STATE) ||
                (a == `SOSC_A_WD0) || (a == `SOSC_A_WD1) ||
                (a >= `SOSC_A_PO_BASE && a <= `SOSC_A_PO_LAST && a[1:0] == 2'h0);
    endfunction : is_rw

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction : merge

    // Reset and margin idle high, matching their pull-ups
    sosc_filter #(.STABLE(`SOSC_MR_FILT_CYC), .RST_VAL(1'b1)) u_mr ( // RULE3 RULE18
        .clk, .rst_n, .pin(manual_reset_n), .level(mr_f));
    sosc_filter #(.STABLE(`SOSC_MR_FILT_CYC), .RST_VAL(1'b1)) u_margin ( // RULE18
        .clk, .rst_n, .pin(margin_n), .level(margin_f));
    sosc_filter #(.STABLE(`SOSC_GPI_FILT_CYC), .RST_VAL(1'b0)) u_supply (
        .clk, .rst_n, .pin(supply_above_lockout), .level(supply_f));
    // Serial and address pins drop short spikes
    sosc_filter #(.STABLE(`SOSC_SPIKE_FILT_CYC), .RST_VAL(1'b1)) u_scl ( // RULE11
        .clk, .rst_n, .pin(scl_in), .level(scl_f));
    sosc_filter #(.STABLE(`SOSC_SPIKE_FILT_CYC), .RST_VAL(1'b1)) u_sda ( // RULE11
        .clk, .rst_n, .pin(sda_in), .level(sda_f));
    sosc_filter #(.STABLE(`SOSC_SPIKE_FILT_CYC), .RST_VAL(1'b0)) u_sel0 ( // RULE11
        .clk, .rst_n, .pin(bus_addr_sel0), .level(sel0_f));
    sosc_filter #(.STABLE(`SOSC_SPIKE_FILT_CYC), .RST_VAL(1'b0)) u_sel1 ( // RULE11
        .clk, .rst_n, .pin(bus_addr_sel1), .level(sel1_f));

    // General inputs only synchronised, keeping them fast and catching short pulses
    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_gpi
            sosc_filter #(.STABLE(`SOSC_GPI_FILT_CYC), .RST_VAL(1'b0)) u_gpi ( // RULE2 RULE5
                .clk, .rst_n, .pin(general_logic_input[g]), .level(gpi_f[g]));
        end
    endgenerate

    // Base tick shared by watchdogs and deassert delays
    assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_cnt <= 16'h0000;
        else
            tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
    end

    // Watchdogs, each with its own clear source
    generate
        for (genvar w = 0; w < 2; w++)
        begin : g_wd
            logic                 gpi_sel;   // Chosen input
            logic                 po_sel;    // Chosen output
            logic                 gpi_prev;  // Input one cycle ago
            logic                 po_prev;   // Output one cycle ago
            logic                 kick;      // Clear event
            sosc_pkg::sosc_clr_type clr_mode;  // Clear source
            assign gpi_sel  = gpi_f[wd_cfg[w][`SOSC_WD_GPI]];
            assign po_sel   = programmable_output[wd_cfg[w][`SOSC_WD_PO]];
            assign clr_mode = sosc_pkg::sosc_clr_type'(wd_cfg[w][`SOSC_WD_CLR]);
            // Combined source: input edges count only while the output is high
            assign kick = (clr_mode == sosc_pkg::SOSC_CLR_GPI  && gpi_sel != gpi_prev) || // RULE15
                          (clr_mode == sosc_pkg::SOSC_CLR_PO   && po_sel != po_prev) ||
                          (clr_mode == sosc_pkg::SOSC_CLR_BOTH && gpi_sel != gpi_prev && po_sel);
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    gpi_prev <= 1'b0;
                    po_prev  <= 1'b0;
                end
                else
                begin
                    gpi_prev <= gpi_sel;
                    po_prev  <= po_sel;
                end
            end
            sosc_wdog u_wdog ( // RULE14
                .clk, .rst_n, .tick, .enable(wd_cfg[w][`SOSC_WD_EN]),
                .code(wd_cfg[w][`SOSC_WD_CODE]), .kick(kick), .expired(wd_exp[w]));
        end
    endgenerate

    // Per-output assert condition and deassert delay
    generate
        for (genvar p = 0; p < 8; p++)
        begin : g_po
            logic        cond;   // Any mapped source active
            logic [16:0] dcnt;   // Ticks since the condition cleared
            logic [16:0] dlim;   // Deassert delay in ticks
            logic [2:0]  dsel;   // Delay code
            logic [16:0] dtab [8]; // Deassert delays by code
            logic        level;  // Conditional state with polarity
            assign dsel = po_cfg[p][`SOSC_PO_DLY];
            assign cond = |(gpi_f & po_cfg[p][`SOSC_PO_GPI_MASK]) | // RULE5
                          |(wd_exp & po_cfg[p][`SOSC_PO_WD_MASK]);  // RULE14
            assign dtab = '{`SOSC_DLY_T0, `SOSC_DLY_T1, `SOSC_DLY_T2, `SOSC_DLY_T3,
                            `SOSC_DLY_T4, `SOSC_DLY_T5, `SOSC_DLY_T6, `SOSC_DLY_T7};
            assign dlim = dtab[dsel];
            assign level = asserted[p] ^ po_cfg[p][`SOSC_PO_ACT_LOW];
            // Priority: lockout, then margin, then manual reset, then normal state
            assign next_po[p] = !supply_f ? 1'b0 : // RULE9
                                !margin_f ? (mode_reg[`SOSC_MODE_FREEZE] ? programmable_output[p] // RULE6 RULE8
                                                                         : margin_state[p]) :
                                (!mr_f && mode_reg[`SOSC_MODE_MR_EN]) ? mr_state[p] : level; // RULE4 RULE7
            // Assert at once, release only after the configured delay
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    asserted[p] <= 1'b0;
                    dcnt        <= 17'h00000;
                end
                else if (cond)
                begin
                    asserted[p] <= 1'b1;
                    dcnt        <= 17'h00000;
                end
                else if (asserted[p] && tick)
                begin
                    if (dcnt == dlim - 17'h00001)
                        asserted[p] <= 1'b0; // RULE16
                    dcnt <= dcnt + 17'h00001;
                end
            end
        end
    endgenerate

    // Output and filtered-pin registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            programmable_output <= 8'h00; // RULE9
            scl_clean           <= 1'b1;
            sda_clean           <= 1'b1;
            bus_address         <= 7'h00;
        end
        else
        begin
            programmable_output <= next_po;
            scl_clean           <= scl_f;
            sda_clean           <= sda_f;
            bus_address         <= {ADDR_BASE[6:2], sel1_f, sel0_f}; // RULE10
        end
    end

    // Write channel: address and data taken together, one write at a time
    logic        wr_fire;    // Write handshake this cycle
    logic        wr_ok;      // Write lands in a register
    logic [31:0] wr_old;     // Current content of the addressed register
    logic [31:0] wr_val;     // Merged value to store
    logic [2:0]  po_idx_w;   // Output index for writes
    assign wr_fire  = s_axi_awvalid && s_axi_awready;
    assign nv_busy  = (nv_cnt != 24'h000000);
    assign wr_ok    = is_rw(s_axi_awaddr) && !nv_busy; // RULE12
    assign po_idx_w = s_axi_awaddr[4:2];
    assign wr_old   = reg_read(s_axi_awaddr);
    assign wr_val   = merge(wr_old, s_axi_wdata, s_axi_wstrb);

    // Handshake and response for writes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SOSC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
            s_axi_wready  <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `SOSC_RESP_OKAY : `SOSC_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Register storage; each accepted write starts the memory-write busy time
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg     <= `SOSC_MODE_RST;
            margin_state <= `SOSC_STATE_RST;
            mr_state     <= `SOSC_STATE_RST;
            wd_cfg       <= '{default: `SOSC_WD_RST};
            po_cfg       <= '{default: `SOSC_PO_RST};
            nv_cnt       <= 24'h000000;
            first_done   <= 1'b0;
        end
        else if (wr_fire && wr_ok)
        begin
            // First write ever costs two write cycles
            nv_cnt     <= first_done ? 24'(NVW_CYCLES) : 24'(2 * NVW_CYCLES); // RULE13
            first_done <= 1'b1;
            if (s_axi_awaddr == `SOSC_A_MODE)
                mode_reg <= wr_val[1:0];
            else if (s_axi_awaddr == `SOSC_A_MARGIN_STATE)
                margin_state <= wr_val[7:0];
            else if (s_axi_awaddr == `SOSC_A_MR_STATE)
                mr_state <= wr_val[7:0];
            else if (s_axi_awaddr == `SOSC_A_WD0)
                wd_cfg[0] <= wr_val[10:0];
            else if (s_axi_awaddr == `SOSC_A_WD1)
                wd_cfg[1] <= wr_val[10:0];
            else
                po_cfg[po_idx_w] <= wr_val[9:0];
        end
        else if (nv_busy)
            nv_cnt <= nv_cnt - 24'h000001;
    end

    // Read decode; unmapped addresses read zero
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        reg_read = 32'h00000000;
        if (a == `SOSC_A_MODE)
            reg_read = {30'h00000000, mode_reg};
        else if (a == `SOSC_A_MARGIN_STATE)
            reg_read = {24'h000000, margin_state};
        else if (a == `SOSC_A_MR_STATE)
            reg_read = {24'h000000, mr_state};
        else if (a == `SOSC_A_WD0)
            reg_read = {21'h000000, wd_cfg[0]};
        else if (a == `SOSC_A_WD1)
            reg_read = {21'h000000, wd_cfg[1]};
        else if (a == `SOSC_A_STATUS)
            reg_read = {5'h00, first_done, nv_busy, supply_f, margin_f, mr_f, gpi_f, wd_exp,
                        asserted, programmable_output};
        else if (a == `SOSC_A_BUSADDR)
            reg_read = {25'h0000000, bus_address};
        else if (is_rw(a))
            reg_read = {22'h000000, po_cfg[a[4:2]]};
    endfunction : reg_read

    logic rd_mapped;   // Read address hits a register
    assign rd_mapped = is_rw(s_axi_araddr) || (s_axi_araddr == `SOSC_A_STATUS) ||
                       (s_axi_araddr == `SOSC_A_BUSADDR);

    // Read channel: one read at a time, data held until taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `SOSC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= reg_read(s_axi_araddr);
                s_axi_rresp  <= rd_mapped ? `SOSC_RESP_OKAY : `SOSC_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule : sosc_top

// *** sosc_checker_sva.sv ***
// Port-level assertions for the supervisor output control block
module sosc_checker #(
    parameter int unsigned NVW_CYCLES = 20,
    parameter logic [6:0]  ADDR_BASE  = 7'h2c
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       supply_above_lockout,
    input wire logic       bus_addr_sel0,
    input wire logic       bus_addr_sel1,
    input wire logic       scl_in,
    input wire logic       scl_clean,
    input wire logic [6:0] bus_address,
    input wire logic [7:0] programmable_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    int unsigned since_ok; // Cycles since the last accepted write
    // Saturating count; a few cycles of slack cover the answer latency
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            since_ok <= NVW_CYCLES;
        else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0)
            since_ok <= 0;
        else if (since_ok < NVW_CYCLES)
            since_ok <= since_ok + 1;
    supply_low_a: assert property (!supply_above_lockout [*6] |-> programmable_output == 8'h00)
        else $error("output active under lockout");
    addr_sel_a: assert property ($stable({bus_addr_sel1, bus_addr_sel0}) [*8] ##1 $stable(bus_addr_sel0) [*6]
        |-> bus_address == {ADDR_BASE[6:2], bus_addr_sel1, bus_addr_sel0}) else $error("bus address wrong");
    spike_drop_a: assert property ($changed(scl_clean) |-> $past(scl_in, 5) == scl_clean
        && $past(scl_in, 6) == scl_clean) else $error("short spike passed the filter");
    busy_refuse_a: assert property ($rose(s_axi_bvalid) && since_ok + 4 < NVW_CYCLES |-> s_axi_bresp == 2'h2)
        else $error("write accepted while memory busy");
    wr_pair_a: assert property ($rose(s_axi_awready) |-> s_axi_wready ##1 !s_axi_awready && !s_axi_wready)
        else $error("write readies not paired");
    bv_after_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid) else $error("no write answer");
    bv_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("answer held");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready && s_axi_rvalid) else $error("read answer late");
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property ($fell(scl_clean));
    cover property (programmable_output != 8'h00);
endmodule : sosc_checker
bind sosc_top sosc_checker #(.NVW_CYCLES(NVW_CYCLES), .ADDR_BASE(ADDR_BASE)) chk_i (.*);

// *** sosc_host.sv ***
// Two-wire host model: serial pins idle high through the pull-ups
module sosc_host (
    input wire logic clk,
    output logic     scl_in,
    output logic     sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {scl_in, sda_in} = 2'h3;
    // Both lines held at s for n cycles; short holds act as noise spikes
    task automatic drive(input logic s, input int n);
        {scl_in, sda_in} <= {s, s};
        repeat (n) @(posedge clk);
    endtask : drive
endmodule : sosc_host

// *** supervisor_output_control_bench.sv ***
// Self-checking bench for the supervisor output control block
module supervisor_output_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scl_in, sda_in, scl_clean, sda_clean;
    logic manual_reset_n, margin_n, supply_above_lockout, bus_addr_sel0, bus_addr_sel1;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, programmable_output;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, general_logic_input;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [6:0]  bus_address;
    int          n_fail, num_checks, cyc;
    // Short tick and write time keep the watchdog run brief
    sosc_top #(.TICK_CYCLES(4), .NVW_CYCLES(20)) dut (.*);
    sosc_host host (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cy(input int n);
        repeat (n) @(posedge clk);
    endtask : cy
    task automatic po(input logic [7:0] e);
        chk(32'(programmable_output), 32'(e));
    endtask : po
    // Write one word, judge the answer, then idle g cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input int g);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do @(posedge clk); while (s_axi_awready !== 1'h1);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge clk); while (s_axi_bvalid !== 1'h1);
        chk(32'(s_axi_bresp), 32'(r));
        cy(g);
    endtask : wr
    task automatic close_out;
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_fail++;
            close_out();
        end
    end
    initial
    begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, supply_above_lockout, bus_addr_sel0} = 6'h0;
        {s_axi_bready, s_axi_rready, manual_reset_n, margin_n, bus_addr_sel1} = 5'h1f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, general_logic_input} = 56'h0000000000000f0;
        cy(3);
        rst_n <= 1'h1;
        cy(20);
        po(8'h00);
        chk(32'(bus_address), 32'({5'h0b, 2'h2}));
        host.drive(1'h0, 3);
        host.drive(1'h1, 12);
        chk(32'({scl_clean, sda_clean}), 32'h3);
        host.drive(1'h0, 12);
        chk(32'({scl_clean, sda_clean}), 32'h0);
        host.drive(1'h1, 12);
        wr(8'h00, 32'h2, 2'h0, 22);
        wr(8'h04, 32'hf0, 2'h2, 20);
        wr(8'h04, 32'hf0, 2'h0, 0);
        wr(8'h08, 32'h0f, 2'h2, 25);
        wr(8'h08, 32'h0f, 2'h0, 25);
        wr(8'h20, 32'h1, 2'h0, 25);
        wr(8'h14, 32'h1, 2'h2, 2);
        wr(8'h40, 32'h1, 2'h2, 2);
        s_axi_araddr <= 8'h80;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (s_axi_rvalid !== 1'h1);
        chk({s_axi_rdata[29:0], s_axi_rresp}, 32'h2);
        supply_above_lockout <= 1'h1;
        general_logic_input <= 4'h1;
        cy(20);
        po(8'h01);
        general_logic_input <= 4'h0;
        cy(4);
        po(8'h01);
        cy(20);
        po(8'h00);
        manual_reset_n <= 1'h0;
        cy(8);
        manual_reset_n <= 1'h1;
        cy(20);
        po(8'h00);
        manual_reset_n <= 1'h0;
        cy(200);
        po(8'h0f);
        margin_n <= 1'h0;
        cy(20);
        po(8'hf0);
        {manual_reset_n, margin_n} <= 2'h3;
        cy(20);
        po(8'h00);
        wr(8'h24, 32'h10, 2'h0, 25);
        wr(8'h0c, 32'h418, 2'h0, 1880);
        po(8'h00);
        cy(200);
        po(8'h02);
        close_out();
    end
endmodule : supervisor_output_control_bench
